// file: src/psr_pkg.sv
// constants for the phy status and identifier register group
package psr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // printed offsets are register indices; byte address is index times four
    localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h01;
    localparam logic [ADDR_W-1:0] IDX_ID_UPPER = 8'h02;
    localparam logic [ADDR_W-1:0] IDX_ID_LOWER = 8'h03;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE = 8'h11;
    localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR = 8'h12;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_ID_UPPER = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_ID_LOWER = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h44;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 8'h48;
    // status field positions
    localparam int BIT_EXT_REGS = 0;
    localparam int BIT_OVERLONG = 1;
    localparam int BIT_LINK = 2;
    localparam int BIT_NEG_CAPABLE = 3;
    localparam int BIT_FAR_FAULT = 4;
    localparam int BIT_NEG_DONE = 5;
    localparam int BIT_MGMT_PRE = 6;
    localparam int BIT_SLOW_HALF = 11;
    localparam int BIT_SLOW_FULL = 12;
    localparam int BIT_FAST_HALF = 13;
    localparam int BIT_FAST_FULL = 14;
    localparam logic [15:0] STATUS_RESET = 16'h7849;
    // identifier field positions
    localparam int OUI_LO_POS = 10;
    localparam int MODEL_POS = 4;
    localparam int REV_POS = 0;
    // interrupt bit positions
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_OVERLONG = 1;
    localparam int IRQ_LINK = 2;
    localparam int IRQ_NEG_DONE = 3;
    localparam int IRQ_W = 4;
endpackage

// file: src/psr_event_latch.sv
// sticky flag: set by a condition, cleared by a read; set wins
`timescale 1ns/1ps
module psr_event_latch (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // event and clear
    input wire logic setIn,
    input wire logic clearIn,
    output logic flag
);
    logic flag_next;
    assign flag_next = setIn ? 1'b1 : (clearIn ? 1'b0 : flag);
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            flag <= 1'b0;
        end else begin
            flag <= flag_next;
        end
    end
endmodule

// file: src/psr_phy_regs.sv
// status and identifier register group with interrupt wrapper
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module psr_phy_regs
    import psr_pkg::*;
#(
    // arbitrary neutral identity values
    parameter logic [21:0] OUI_VALUE = 22'h2A5A5,
    parameter logic [5:0] MODEL_VALUE = 6'h05,
    parameter logic [3:0] REV_VALUE = 4'h1
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    // phy line state, asynchronous
    input wire logic farEndFault,
    input wire logic overlongTransmit,
    input wire logic linkUp,
    input wire logic negotiationDone,
    // interrupt
    output logic irq
);
    logic rstMeta_reg, rstN_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_reg <= 1'b0;
            rstN_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstN_reg <= rstMeta_reg;
        end
    end

    // two-stage synchronisers for line inputs
    logic [3:0] syncA_reg, syncB_reg;
    always_ff @(posedge clk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            syncA_reg <= 4'h0;
            syncB_reg <= 4'h0;
        end else begin
            syncA_reg <= {negotiationDone, linkUp, overlongTransmit,
                farEndFault};
            syncB_reg <= syncA_reg;
        end
    end
    wire faultS = syncB_reg[0];
    wire overlongS = syncB_reg[1];
    wire linkS = syncB_reg[2];
    wire negDoneS = syncB_reg[3];

    wire selStatus = regAddr == ADDR_STATUS;
    wire selIdUp = regAddr == ADDR_ID_UPPER;
    wire selIdLo = regAddr == ADDR_ID_LOWER;
    wire selIrqSt = regAddr == ADDR_IRQ_STATUS;
    wire selIrqEn = regAddr == ADDR_IRQ_ENABLE;
    wire selIrqClr = regAddr == ADDR_IRQ_CLEAR;
    wire statusRead = regRead && selStatus;

    // read-clear flags; an event in the clearing cycle survives
    logic faultFlag, overlongFlag;
    psr_event_latch uFault (
        .clk(clk), .rstN(rstN_reg), .setIn(faultS),
        .clearIn(statusRead), .flag(faultFlag)
    );
    psr_event_latch uOverlong (
        .clk(clk), .rstN(rstN_reg), .setIn(overlongS),
        .clearIn(statusRead), .flag(overlongFlag)
    );

    // live status word; reserved bits tied low
    logic [15:0] statusWord;
    always_comb begin
        statusWord = 16'h0000;
        statusWord[BIT_FAST_FULL] = 1'b1;
        statusWord[BIT_FAST_HALF] = 1'b1;
        statusWord[BIT_SLOW_FULL] = 1'b1;
        statusWord[BIT_SLOW_HALF] = 1'b1;
        statusWord[BIT_MGMT_PRE] = STATUS_RESET[BIT_MGMT_PRE];
        statusWord[BIT_NEG_DONE] = negDoneS;
        statusWord[BIT_FAR_FAULT] = faultFlag;
        statusWord[BIT_NEG_CAPABLE] = 1'b1;
        statusWord[BIT_LINK] = linkS;
        statusWord[BIT_OVERLONG] = overlongFlag;
        statusWord[BIT_EXT_REGS] = 1'b1;
    end

    // identifier words
    wire [15:0] idUpper = OUI_VALUE[21:6];
    wire [15:0] idLower = {OUI_VALUE[5:0], MODEL_VALUE, REV_VALUE};

    // interrupt: sticky bits on rising edges of link and negotiation done, on the level of fault and overlong
    logic linkPrev_reg, negPrev_reg;
    logic [IRQ_W-1:0] irqStatus_reg, irqStatus_next;
    logic [IRQ_W-1:0] irqEnable_reg, irqEnable_next;
    wire [IRQ_W-1:0] irqEvents = {negDoneS & ~negPrev_reg,
        linkS & ~linkPrev_reg, overlongS, faultS};
    wire [IRQ_W-1:0] irqClear = (regWrite && selIrqClr) ?
        regWdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
    assign irqStatus_next = irqEvents | (irqStatus_reg & ~irqClear);
    assign irqEnable_next = (regWrite && selIrqEn) ?
        regWdata[IRQ_W-1:0] : irqEnable_reg;
    wire irq_next = |(irqStatus_next & irqEnable_next);

    always_ff @(posedge clk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            linkPrev_reg <= 1'b0;
            negPrev_reg <= 1'b0;
            irqStatus_reg <= {IRQ_W{1'b0}};
            irqEnable_reg <= {IRQ_W{1'b0}};
            irq <= 1'b0;
        end else begin
            linkPrev_reg <= linkS;
            negPrev_reg <= negDoneS;
            irqStatus_reg <= irqStatus_next;
            irqEnable_reg <= irqEnable_next;
            irq <= irq_next;
        end
    end

    // read mux; writes to the phy words have no target at all
    logic [DATA_W-1:0] rdMux;
    always_comb begin
        rdMux = '0;
        if (selStatus) begin
            rdMux = {16'h0000, statusWord};
        end else if (selIdUp) begin
            rdMux = {16'h0000, idUpper};
        end else if (selIdLo) begin
            rdMux = {16'h0000, idLower};
        end else if (selIrqSt) begin
            rdMux = {{(DATA_W-IRQ_W){1'b0}}, irqStatus_reg};
        end else if (selIrqEn) begin
            rdMux = {{(DATA_W-IRQ_W){1'b0}}, irqEnable_reg};
        end
    end

    always_ff @(posedge clk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            regRdata <= '0;
        end else begin
            regRdata <= regRead ? rdMux : '0;
        end
    end

    // checks
    property p_fault_clear;
        @(posedge clk) disable iff (!rstN_reg)
        (statusRead && !faultS) |=> !faultFlag;
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("fault flag not cleared by read");

    property p_fault_hold;
        @(posedge clk) disable iff (!rstN_reg)
        (faultFlag && !statusRead) |=> faultFlag;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault flag dropped without read");

    property p_overlong_set;
        @(posedge clk) disable iff (!rstN_reg)
        overlongS |=> overlongFlag;
    endproperty
    a_overlong_set: assert property (p_overlong_set)
        else $error("overlong flag not set");

    property p_neg_done;
        @(posedge clk) disable iff (!rstN_reg)
        (regRead && selStatus) |=> regRdata[BIT_NEG_DONE] == $past(negDoneS);
    endproperty
    a_neg_done: assert property (p_neg_done)
        else $error("negotiation done bit wrong");

    property p_link;
        @(posedge clk) disable iff (!rstN_reg)
        (regRead && selStatus) |=> regRdata[BIT_LINK] == $past(linkS);
    endproperty
    a_link: assert property (p_link)
        else $error("link bit wrong");

    property p_fixed;
        @(posedge clk) disable iff (!rstN_reg)
        (regRead && selStatus) |=>
            (regRdata[15:0] & 16'hF849) == 16'h7849 && regRdata[15:7] ==
            9'h0F0 ;
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed status bits wrong");

    property p_ext;
        @(posedge clk) disable iff (!rstN_reg)
        (regRead && selStatus) |=>
            regRdata[BIT_EXT_REGS] && regRdata[14:11] == 4'hF;
    endproperty
    a_ext: assert property (p_ext)
        else $error("capability bits wrong");

    property p_idlo;
        @(posedge clk) disable iff (!rstN_reg)
        (regRead && selIdLo) |=> regRdata == {16'h0000, OUI_VALUE[5:0],
            MODEL_VALUE, REV_VALUE};
    endproperty
    a_idlo: assert property (p_idlo)
        else $error("lower identifier wrong");

    property p_idup;
        @(posedge clk) disable iff (!rstN_reg)
        (regRead && selIdUp) |=> regRdata == {16'h0000, OUI_VALUE[21:6]};
    endproperty
    a_idup: assert property (p_idup)
        else $error("upper identifier wrong");
endmodule

// file: tb/tb_psr_phy_regs.sv
// self-checking bench for the phy status and identifier register group
`timescale 1ns/1ps
module tb_psr_phy_regs;
    import psr_pkg::*;
    // identity values are arbitrary, handed to the design below
    localparam logic [21:0] OUI = 22'h2A5A5;
    localparam logic [5:0] MODEL = 6'h05;
    localparam logic [3:0] REV = 4'h1;
    localparam logic [31:0] BASE = 32'h00007849;
    logic clk;
    logic arst_n;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata;
    logic regWrite;
    logic regRead;
    logic [DATA_W-1:0] regRdata;
    logic [3:0] phyIn;
    logic irq;
    int n_fail;
    int n_compared;
    int cycles = 0;
    int pos[4] = '{BIT_FAR_FAULT, BIT_OVERLONG, BIT_LINK, BIT_NEG_DONE};

    psr_phy_regs #(.OUI_VALUE(OUI), .MODEL_VALUE(MODEL), .REV_VALUE(REV))
    u_psr_phy_regs (
        .clk(clk),
        .arst_n(arst_n),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdata(regRdata),
        .farEndFault(phyIn[0]),
        .overlongTransmit(phyIn[1]),
        .linkUp(phyIn[2]),
        .negotiationDone(phyIn[3]),
        .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hang is cut short well beyond the fewer than two hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic idle(int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, sampled there
    task automatic rd(logic [ADDR_W-1:0] a, logic [31:0] exp, string name);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(name, regRdata, exp);
    endtask

    task automatic chk_irq(logic exp);
        idle(3);
        #1;
        chk("irq", {31'h0, irq}, {31'h0, exp});
    endtask

    initial begin
        arst_n = 1'b0;
        regAddr = '0;
        regWdata = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
        phyIn = 4'h0;
        n_fail = 0;
        n_compared = 0;
        idle(12);
        arst_n <= 1'b1;
        idle(3);
        rd(ADDR_STATUS, BASE, "status reset");
        rd(ADDR_ID_UPPER, {16'h0, OUI[21:6]}, "id upper");
        rd(ADDR_ID_LOWER, {16'h0, OUI[5:0], MODEL, REV}, "id lower");
        rd(8'h7C, 32'h0, "unmapped");
        rd(ADDR_IRQ_STATUS, 32'h0, "irq status reset");
        $display("test reset values done");
        wr(ADDR_STATUS, 32'hFFFFFFFF);
        wr(ADDR_ID_UPPER, 32'hFFFFFFFF);
        wr(ADDR_ID_LOWER, 32'h0);
        rd(ADDR_STATUS, BASE, "status after write");
        rd(ADDR_ID_UPPER, {16'h0, OUI[21:6]}, "upper after write");
        rd(ADDR_ID_LOWER, {16'h0, OUI[5:0], MODEL, REV}, "lower after write");
        $display("test write ignored done");
        // sticky flags must survive the input dropping; level bits must not
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) phyIn[i] <= 1'b1;
            idle(6);
            rd(ADDR_STATUS, BASE | (32'h1 << pos[i]), "status set");
            @(posedge clk) phyIn[i] <= 1'b0;
            idle(6);
            if (i < 2) begin
                rd(ADDR_STATUS, BASE | (32'h1 << pos[i]), "held");
            end
            rd(ADDR_STATUS, BASE, "status cleared");
        end
        $display("test status events done");
        rd(ADDR_IRQ_STATUS, 32'hF, "irq status events");
        chk_irq(1'b0);
        wr(ADDR_IRQ_ENABLE, 32'hF);
        rd(ADDR_IRQ_ENABLE, 32'hF, "irq enable");
        chk_irq(1'b1);
        wr(ADDR_IRQ_CLEAR, 32'h3);
        rd(ADDR_IRQ_STATUS, 32'hC, "irq status part clear");
        chk_irq(1'b1);
        wr(ADDR_IRQ_CLEAR, 32'hC);
        rd(ADDR_IRQ_STATUS, 32'h0, "irq status clear");
        chk_irq(1'b0);
        wr(ADDR_IRQ_ENABLE, 32'h1);
        @(posedge clk) phyIn[1] <= 1'b1;
        idle(2);
        @(posedge clk) phyIn[1] <= 1'b0;
        idle(6);
        rd(ADDR_IRQ_STATUS, 32'h2, "irq status masked");
        chk_irq(1'b0);
        @(posedge clk) phyIn[0] <= 1'b1;
        idle(2);
        @(posedge clk) phyIn[0] <= 1'b0;
        chk_irq(1'b1);
        wr(ADDR_IRQ_CLEAR, 32'h3);
        chk_irq(1'b0);
        $display("test interrupts done");
        tally_and_finish();
    end
endmodule
